// ---- core/csrfe_pkg.sv ----
package csrfe_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W  = 3;

  // address port field positions
  localparam int unsigned ADDR_BYTE_MODE_BIT  = 7;
  localparam int unsigned ADDR_SEL_HI         = 3;
  localparam int unsigned ADDR_SEL_LO         = 1;
  localparam int unsigned ADDR_UPPER_BYTE_BIT = 0;

  // selector values
  localparam logic [2:0] SEL_PRIMARY    = 3'h0;
  localparam logic [2:0] SEL_LAST_VALID = 3'h5;

  // primary control/status field positions
  localparam int unsigned CS_TX_DEMAND_BIT  = 15;
  localparam int unsigned CS_STOPPED_BIT    = 14;
  localparam int unsigned CS_TX_DISABLE_BIT = 13;
  localparam int unsigned CS_RX_DISABLE_BIT = 12;
  localparam int unsigned CS_TX_ACTIVE_BIT  = 11;
  localparam int unsigned CS_RX_ACTIVE_BIT  = 10;
  localparam int unsigned CS_IRQ_ENABLE_BIT = 9;
  localparam int unsigned CS_IRQ_FLAG_BIT   = 8;
  localparam int unsigned CS_CAUSE_HI       = 7;
  localparam int unsigned CS_CAUSE_LO       = 1;
  localparam int unsigned CAUSE_W           = 7;

  // cause vector index, bit 0 of the vector sits at status bit 1
  localparam int unsigned CAUSE_RX_DONE      = 0;
  localparam int unsigned CAUSE_TX_DONE      = 1;
  localparam int unsigned CAUSE_PRIMITIVE    = 2;
  localparam int unsigned CAUSE_TX_UNDERRUN  = 3;
  localparam int unsigned CAUSE_RX_OVERRUN   = 4;
  localparam int unsigned CAUSE_MISSED_FRAME = 5;
  localparam int unsigned CAUSE_MEM_TIMEOUT  = 6;

  // reset values
  localparam logic [15:0]  RESET_WORD  = 16'h0000;
  localparam logic [6:0]   CAUSE_CLEAR = 7'h00;
  localparam logic [7:0]   BYTE_ZERO   = 8'h00;

  // memory ready timeout in system clocks
  localparam int unsigned  MEM_TIMEOUT_CYCLES = 256;
  localparam logic [8:0]   MEM_TIMEOUT_LAST   = 9'(MEM_TIMEOUT_CYCLES - 1);
  localparam logic [8:0]   MEM_COUNT_ZERO     = 9'h000;
  localparam logic [8:0]   MEM_COUNT_ONE      = 9'h001;

  typedef enum logic [1:0] {
    CSRFE_MT_IDLE = 2'b01,
    CSRFE_MT_WAIT = 2'b10
  } csrfe_mt_state_type;

endpackage

// ---- core/csrfe_store_if.sv ----
`timescale 1ns/1ns
interface csrfe_store_if;
  logic        wr_en;
  logic [2:0]  index;
  logic [15:0] wdata;
  logic [1:0]  byte_en;
  logic [15:0] rdata;

  modport front (output wr_en, output index, output wdata, output byte_en, input rdata);
  modport store (input wr_en, input index, input wdata, input byte_en, output rdata);
endinterface

// ---- core/csrfe_aux_store.sv ----
`timescale 1ns/1ns
module csrfe_aux_store (
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  csrfe_store_if.store st
);
  // storage for selector values 1..5; value 0 lives in the front end
  logic [15:0] word_r [1:5];

  genvar gi;
  generate
    for (gi = 1; gi <= 5; gi++) begin : g_word
      wire hit = st.wr_en && (st.index == 3'(gi));
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          word_r[gi] <= csrfe_pkg::RESET_WORD;
        end else if (hit) begin
          if (st.byte_en[0]) begin
            word_r[gi][7:0] <= st.wdata[7:0];
          end
          if (st.byte_en[1]) begin
            word_r[gi][15:8] <= st.wdata[15:8];
          end
        end
      end
    end
  endgenerate

  wire in_range = (st.index != csrfe_pkg::SEL_PRIMARY) &&
                  (st.index <= csrfe_pkg::SEL_LAST_VALID);
  assign st.rdata = in_range ? word_r[st.index] : csrfe_pkg::RESET_WORD;
endmodule

// ---- core/csrfe_front.sv ----
`timescale 1ns/1ns
// How it works
// - host writes the selector to the address port, then accesses the data port.
// - selector holds across data port accesses until the address port is rewritten.
// - port select high targets the address port, low the data port.
// - address bit 7 picks byte-wide transfers; reset clears it.
// - address bits 3..1 select one of six registers; reset clears them.
// - address bit 0 picks the upper byte in byte mode; reset clears it.
// - data port writes load, reads return, the selected register.
// - writing one to bit 15 demands a ring scan; cleared once taken.
// - bit 14 shows the stopped phase, set by reset or stop primitive.
// - tx disable lets the current frame finish, then stops transmit ring use.
// - rx disable stops reception after current frame; sends RNR, RR on clearing, only while link is up.
// - tx active sets on start or disable clearing; clears on disable, stop, reset.
// - rx active sets on start or disable clearing; clears on disable, stop, reset.
// - interrupt pin low when enable and flag both set; enable cleared by stop.
// - bit 8 is the OR of the seven cause flags.
// - cause flags set by the device, cleared by writing one, reset or stop.
// - cause flags at bits 7..1; missing ready for 256 cycles sets memory error.
module csrfe_front (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        bus_sel,
  input  wire logic        bus_write,
  input  wire logic        port_select,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata_r,
  output logic             bus_ack_r,
  input  wire logic        start_prim,
  input  wire logic        stop_prim,
  input  wire logic        demand_taken,
  input  wire logic        tx_frame_busy,
  input  wire logic        rx_frame_busy,
  input  wire logic        link_up,
  input  wire logic [6:0]  cause_set,
  input  wire logic        dma_addr_strobe,
  input  wire logic        dma_ready,
  output logic             transmit_demand_r,
  output logic             stopped_r,
  output logic             tx_ring_active_r,
  output logic             rx_ring_active_r,
  output logic             byte_wide_mode_r,
  output logic             send_rnr_r,
  output logic             send_rr_r,
  output logic             irq_n_r
);

  csrfe_store_if st ();

  csrfe_aux_store u_store (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .st      (st)
  );

  logic [2:0]                    register_selector_r;
  logic                          upper_byte_select_r;
  logic                          tx_ring_disable_r;
  logic                          rx_ring_disable_r;
  logic                          irq_enable_r;
  logic [6:0]                    cause_r;
  logic [8:0]                    mt_count_r;
  csrfe_pkg::csrfe_mt_state_type mt_state_r;

  // access decode
  wire addr_wr = bus_sel && bus_write && port_select;
  wire data_wr = bus_sel && bus_write && !port_select;
  wire data_rd = bus_sel && !bus_write && !port_select;
  wire sel_ok  = register_selector_r <= csrfe_pkg::SEL_LAST_VALID;
  wire sel_pri = register_selector_r == csrfe_pkg::SEL_PRIMARY;

  // byte-wide mode puts the byte on lanes 7..0 and steers it by the upper select
  wire [1:0]  wr_be   = !byte_wide_mode_r ? 2'b11 :
                        (upper_byte_select_r ? 2'b10 : 2'b01);
  wire [15:0] wr_word = byte_wide_mode_r ? {bus_wdata[7:0], bus_wdata[7:0]} : bus_wdata;

  wire pri_wr    = data_wr && sel_pri;
  wire pri_wr_hi = pri_wr && wr_be[1];
  wire pri_wr_lo = pri_wr && wr_be[0];

  assign st.wr_en   = data_wr && sel_ok && !sel_pri;
  assign st.index   = register_selector_r;
  assign st.wdata   = wr_word;
  assign st.byte_en = wr_be;

  // memory ready watchdog
  wire mt_expire = (mt_state_r == csrfe_pkg::CSRFE_MT_WAIT) && !dma_ready &&
                   (mt_count_r == csrfe_pkg::MEM_TIMEOUT_LAST);
  csrfe_pkg::csrfe_mt_state_type mt_state_nxt;
  logic [8:0] mt_count_nxt;

  always_comb begin
    mt_state_nxt = mt_state_r;
    mt_count_nxt = mt_count_r;
    unique case (mt_state_r)
      csrfe_pkg::CSRFE_MT_IDLE: begin
        if (dma_addr_strobe && !dma_ready) begin
          mt_state_nxt = csrfe_pkg::CSRFE_MT_WAIT;
          mt_count_nxt = csrfe_pkg::MEM_COUNT_ONE;
        end
      end
      csrfe_pkg::CSRFE_MT_WAIT: begin
        if (dma_ready || mt_expire || stopped_r) begin
          mt_state_nxt = csrfe_pkg::CSRFE_MT_IDLE;
          mt_count_nxt = csrfe_pkg::MEM_COUNT_ZERO;
        end else begin
          mt_count_nxt = mt_count_r + csrfe_pkg::MEM_COUNT_ONE;
        end
      end
      default: begin
        mt_state_nxt = csrfe_pkg::CSRFE_MT_IDLE;
        mt_count_nxt = csrfe_pkg::MEM_COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mt_state_r <= csrfe_pkg::CSRFE_MT_IDLE;
      mt_count_r <= csrfe_pkg::MEM_COUNT_ZERO;
    end else begin
      mt_state_r <= mt_state_nxt;
      mt_count_r <= mt_count_nxt;
    end
  end

  // cause flags: device sets win over a write-one clear in the same cycle
  wire [6:0] cause_evt   = {cause_set[6] | mt_expire, cause_set[5:0]};
  wire [6:0] cause_w1c   = pri_wr_lo ? wr_word[csrfe_pkg::CS_CAUSE_HI:csrfe_pkg::CS_CAUSE_LO]
                                     : csrfe_pkg::CAUSE_CLEAR;
  wire [6:0] cause_nxt   = stop_prim ? csrfe_pkg::CAUSE_CLEAR
                                     : ((cause_r & ~cause_w1c) | cause_evt);
  wire       memory_timeout_error_hold   = cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT];
  // any memory error source, watchdog or engine, takes both rings down
  wire       memory_timeout_error_evt    = cause_evt[csrfe_pkg::CAUSE_MEM_TIMEOUT];
  wire       irq_flag    = |cause_r;

  // control bits
  wire irq_en_nxt = stop_prim ? 1'b0 :
                    (pri_wr_hi ? wr_word[csrfe_pkg::CS_IRQ_ENABLE_BIT] : irq_enable_r);
  wire tx_dis_nxt = pri_wr_hi ? wr_word[csrfe_pkg::CS_TX_DISABLE_BIT] : tx_ring_disable_r;
  wire rx_dis_nxt = pri_wr_hi ? wr_word[csrfe_pkg::CS_RX_DISABLE_BIT] : rx_ring_disable_r;
  wire demand_wr  = pri_wr_hi && wr_word[csrfe_pkg::CS_TX_DEMAND_BIT];
  // a fresh demand in the taking cycle survives the clear
  wire demand_nxt = demand_wr || (transmit_demand_r && !demand_taken && !stop_prim);
  wire stop_nxt   = stop_prim ? 1'b1 : (start_prim ? 1'b0 : stopped_r);
  wire running    = !stopped_r && !memory_timeout_error_hold;

  // ring activity: on disable the current frame finishes before the ring is released; stop and memory error release it at once
  wire tx_act_nxt = (stop_prim || memory_timeout_error_evt) ? 1'b0 :
                    ((start_prim || running) && !tx_ring_disable_r) ? 1'b1 :
                    (tx_ring_disable_r && !tx_frame_busy) ? 1'b0 : tx_ring_active_r;
  wire rx_act_nxt = (stop_prim || memory_timeout_error_evt) ? 1'b0 :
                    ((start_prim || running) && !rx_ring_disable_r) ? 1'b1 :
                    (rx_ring_disable_r && !rx_frame_busy) ? 1'b0 : rx_ring_active_r;

  wire rx_dis_rise = rx_dis_nxt && !rx_ring_disable_r;
  wire rx_dis_fall = !rx_dis_nxt && rx_ring_disable_r;

  // read mux
  wire [15:0] addr_word = {csrfe_pkg::BYTE_ZERO, byte_wide_mode_r, 3'h0,
                           register_selector_r, upper_byte_select_r};
  wire [15:0] pri_word  = {transmit_demand_r, stopped_r, tx_ring_disable_r, rx_ring_disable_r,
                           tx_ring_active_r, rx_ring_active_r, irq_enable_r, irq_flag,
                           cause_r, 1'b0};
  wire [15:0] data_word = !sel_ok ? csrfe_pkg::RESET_WORD :
                          (sel_pri ? pri_word : st.rdata);
  wire [15:0] port_word = port_select ? addr_word : data_word;
  // the address port has no upper byte, so only data port reads are steered
  wire        rd_steer  = byte_wide_mode_r && !port_select;
  wire [15:0] rd_word   = !rd_steer ? port_word :
                          {csrfe_pkg::BYTE_ZERO,
                           (upper_byte_select_r ? port_word[15:8] : port_word[7:0])};

  // address port
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byte_wide_mode_r    <= 1'b0;
      register_selector_r <= 3'h0;
      upper_byte_select_r <= 1'b0;
    end else if (addr_wr) begin
      byte_wide_mode_r    <= bus_wdata[csrfe_pkg::ADDR_BYTE_MODE_BIT];
      register_selector_r <= bus_wdata[csrfe_pkg::ADDR_SEL_HI:csrfe_pkg::ADDR_SEL_LO];
      upper_byte_select_r <= bus_wdata[csrfe_pkg::ADDR_UPPER_BYTE_BIT];
    end
  end

  // primary control/status state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_demand_r <= 1'b0;
      stopped_r         <= 1'b1;
      tx_ring_disable_r <= 1'b0;
      rx_ring_disable_r <= 1'b0;
      tx_ring_active_r  <= 1'b0;
      rx_ring_active_r  <= 1'b0;
      irq_enable_r      <= 1'b0;
      cause_r           <= csrfe_pkg::CAUSE_CLEAR;
    end else begin
      transmit_demand_r <= demand_nxt;
      stopped_r         <= stop_nxt;
      tx_ring_disable_r <= tx_dis_nxt;
      rx_ring_disable_r <= rx_dis_nxt;
      tx_ring_active_r  <= tx_act_nxt;
      rx_ring_active_r  <= rx_act_nxt;
      irq_enable_r      <= irq_en_nxt;
      cause_r           <= cause_nxt;
    end
  end

  // pin and pulse outputs, all from flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_n_r     <= 1'b1;
      send_rnr_r  <= 1'b0;
      send_rr_r   <= 1'b0;
      bus_ack_r   <= 1'b0;
      bus_rdata_r <= csrfe_pkg::RESET_WORD;
    end else begin
      irq_n_r    <= !(irq_en_nxt && (|cause_nxt));
      send_rnr_r <= rx_dis_rise && link_up;
      send_rr_r  <= rx_dis_fall && link_up;
      bus_ack_r  <= bus_sel;
      if (bus_sel && !bus_write) begin
        bus_rdata_r <= rd_word;
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_selector_hold: assert property (
    !addr_wr |=> $stable(register_selector_r))
    else $error("selector changed without address port write");

  chk_selector_load: assert property (
    addr_wr |=> register_selector_r == $past(bus_wdata[3:1]))
    else $error("selector not loaded from address write");

  chk_demand_kept: assert property (
    demand_wr |=> transmit_demand_r)
    else $error("transmit demand lost");

  chk_stop_clears: assert property (
    stop_prim |=> stopped_r && !tx_ring_active_r && !rx_ring_active_r && !irq_enable_r
                  && cause_r == 7'h00)
    else $error("stop primitive did not clear state");

  chk_tx_release: assert property (
    tx_ring_disable_r && tx_frame_busy && !stop_prim && !memory_timeout_error_evt && tx_ring_active_r
    |=> tx_ring_active_r)
    else $error("transmit ring dropped during frame");

  chk_rx_idle_off: assert property (
    (rx_ring_disable_r && !rx_frame_busy)[*2] |-> !rx_ring_active_r)
    else $error("receive ring stayed active");

  chk_irq_pin: assert property (
    ##1 (irq_n_r == !(irq_enable_r && (|cause_r))))
    else $error("interrupt pin mismatch");

  chk_set_wins: assert property (
    (cause_evt[0] && !stop_prim) |=> cause_r[0])
    else $error("cause flag event lost");

  // checker-side count of unbroken waiting since the strobe, kept apart from the watchdog
  logic [8:0] chk_wait_r;
  wire        chk_wait_go   = (mt_state_r == csrfe_pkg::CSRFE_MT_IDLE) && dma_addr_strobe &&
                              !dma_ready && !stopped_r;
  wire        chk_wait_keep = !dma_ready && !stopped_r && !stop_prim;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chk_wait_r <= csrfe_pkg::MEM_COUNT_ZERO;
    end else if (chk_wait_go) begin
      chk_wait_r <= csrfe_pkg::MEM_COUNT_ONE;
    end else if (chk_wait_keep && (chk_wait_r != csrfe_pkg::MEM_COUNT_ZERO)) begin
      chk_wait_r <= chk_wait_r + csrfe_pkg::MEM_COUNT_ONE;
    end else begin
      chk_wait_r <= csrfe_pkg::MEM_COUNT_ZERO;
    end
  end

  chk_mem_timeout: assert property (
    (chk_wait_r == csrfe_pkg::MEM_TIMEOUT_LAST) && chk_wait_keep
    |=> cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT])
    else $error("memory timeout not flagged");

  chk_no_early_timeout: assert property (
    (chk_wait_r != csrfe_pkg::MEM_COUNT_ZERO) && (chk_wait_r < csrfe_pkg::MEM_TIMEOUT_LAST) &&
    !cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT] && !cause_set[csrfe_pkg::CAUSE_MEM_TIMEOUT]
    |=> !cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT])
    else $error("memory timeout flagged early");

  chk_bad_sel_read: assert property (
    data_rd && !sel_ok |=> bus_rdata_r == 16'h0000)
    else $error("unmapped selector read not zero");

  chk_byte_mode_load: assert property (
    addr_wr |=> byte_wide_mode_r == $past(bus_wdata[csrfe_pkg::ADDR_BYTE_MODE_BIT]))
    else $error("byte mode not loaded from address write");

  chk_upper_load: assert property (
    addr_wr |=> upper_byte_select_r == $past(bus_wdata[csrfe_pkg::ADDR_UPPER_BYTE_BIT]))
    else $error("upper byte select not loaded from address write");

  chk_bad_sel_write: assert property (
    data_wr && !sel_ok |-> !st.wr_en && !pri_wr)
    else $error("unmapped selector write reached a register");

  chk_rnr_pulse: assert property (
    (!rx_ring_disable_r && link_up) ##1 rx_ring_disable_r |-> send_rnr_r)
    else $error("busy response not sent");

  chk_rr_pulse: assert property (
    (rx_ring_disable_r && link_up) ##1 !rx_ring_disable_r |-> send_rr_r)
    else $error("ready response not sent");

  chk_tx_on: assert property (
    !stopped_r && !tx_ring_disable_r && !cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT] &&
    !stop_prim && !memory_timeout_error_evt |=> tx_ring_active_r)
    else $error("transmit ring not active");

  chk_rx_on: assert property (
    !stopped_r && !rx_ring_disable_r && !cause_r[csrfe_pkg::CAUSE_MEM_TIMEOUT] &&
    !stop_prim && !memory_timeout_error_evt |=> rx_ring_active_r)
    else $error("receive ring not active");

  chk_demand_clear: assert property (
    transmit_demand_r && demand_taken && !demand_wr |=> !transmit_demand_r)
    else $error("transmit demand not cleared after use");

  chk_zero_write: assert property (
    pri_wr_lo && !stop_prim && !(|cause_evt)
    |=> cause_r == ($past(cause_r) &
                    ~$past(wr_word[csrfe_pkg::CS_CAUSE_HI:csrfe_pkg::CS_CAUSE_LO])))
    else $error("cause flags not cleared by ones only");

  chk_memory_timeout_error_rings: assert property (
    memory_timeout_error_evt |=> !tx_ring_active_r && !rx_ring_active_r)
    else $error("rings left active after memory error");

endmodule

// ---- test/csrfe_host_model.sv ----
`timescale 1ns/1ns
module csrfe_host_model (
  input  wire logic        sys_clk,
  input  wire logic        bus_ack_r,
  input  wire logic [15:0] bus_rdata_r,
  output logic             bus_sel,
  output logic             bus_write,
  output logic             port_select,
  output logic      [15:0] bus_wdata
);
  initial begin
    bus_sel = 1'b0;
    bus_write = 1'b0;
    port_select = 1'b0;
    bus_wdata = 16'hffff;
  end

  // one strobe cycle per access; released data shows the inverse so nothing stale looks held
  task automatic xfer(input logic wr, input logic port, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    q = 16'hxxxx;
    @(posedge sys_clk);
    bus_sel     <= 1'b1;
    bus_write   <= wr;
    port_select <= port;
    bus_wdata   <= d;
    @(posedge sys_clk);
    bus_sel   <= 1'b0;
    bus_wdata <= ~d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (bus_ack_r !== 1'b1 && n < 4);
    if (bus_ack_r === 1'b1) q = bus_rdata_r;
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic        sys_clk, resetn, start_prim, stop_prim, demand_taken;
  logic        tx_frame_busy, rx_frame_busy, link_up, dma_addr_strobe, dma_ready;
  logic [6:0]  cause_set;
  logic        bus_sel, bus_write, port_select, bus_ack_r;
  logic [15:0] bus_wdata, bus_rdata_r;
  logic        transmit_demand_r, stopped_r, tx_ring_active_r, rx_ring_active_r;
  logic        byte_wide_mode_r, send_rnr_r, send_rr_r, irq_n_r;
  int          errors, tests_run, cycles, rnr_cnt, rr_cnt;
  typedef struct {
    logic [2:0]  sel;
    logic [15:0] wdata;
    logic [15:0] exp;
  } csrfe_row_type;
  csrfe_row_type rows [7] = '{'{3'h6, 16'h5555, 16'h0000}, '{3'h7, 16'haaaa, 16'h0000},
    '{3'h1, 16'h1234, 16'h1234}, '{3'h2, 16'habcd, 16'habcd}, '{3'h3, 16'hffff, 16'hffff},
    '{3'h4, 16'h0001, 16'h0001}, '{3'h5, 16'h8000, 16'h8000}};

  csrfe_front dut (.sys_clk(sys_clk), .resetn(resetn), .bus_sel(bus_sel),
    .bus_write(bus_write), .port_select(port_select), .bus_wdata(bus_wdata),
    .bus_rdata_r(bus_rdata_r), .bus_ack_r(bus_ack_r), .start_prim(start_prim),
    .stop_prim(stop_prim), .demand_taken(demand_taken), .tx_frame_busy(tx_frame_busy),
    .rx_frame_busy(rx_frame_busy), .link_up(link_up), .cause_set(cause_set),
    .dma_addr_strobe(dma_addr_strobe), .dma_ready(dma_ready),
    .transmit_demand_r(transmit_demand_r), .stopped_r(stopped_r),
    .tx_ring_active_r(tx_ring_active_r), .rx_ring_active_r(rx_ring_active_r),
    .byte_wide_mode_r(byte_wide_mode_r), .send_rnr_r(send_rnr_r), .send_rr_r(send_rr_r),
    .irq_n_r(irq_n_r));
  csrfe_host_model host (.sys_clk(sys_clk), .bus_ack_r(bus_ack_r), .bus_rdata_r(bus_rdata_r),
    .bus_sel(bus_sel), .bus_write(bus_write), .port_select(port_select),
    .bus_wdata(bus_wdata));

  always #25 sys_clk = ~sys_clk;

  task automatic final_report;
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ceiling well above the roughly 570 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (send_rnr_r === 1'b1) rnr_cnt++;
    if (send_rr_r === 1'b1) rr_cnt++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t run hung", $time);
      final_report();
    end
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic port, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b1, port, d, q);
  endtask

  task automatic rd(input logic port, input logic [15:0] exp, input string msg);
    logic [15:0] q;
    host.xfer(1'b0, port, 16'h0000, q);
    check16(q, exp, msg);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
  endtask

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {start_prim, stop_prim, demand_taken, tx_frame_busy, rx_frame_busy, link_up} = 6'h00;
    {dma_addr_strobe, dma_ready} = 2'b01;
    cause_set = 7'h00;
    cyc(3);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(1'b1, {12'h000, rows[i].sel, 1'b0});
      rd(1'b1, {12'h000, rows[i].sel, 1'b0}, "address port");
      wr(1'b0, rows[i].wdata);
      rd(1'b0, rows[i].exp, "data port");
    end
    repeat (2) rd(1'b0, 16'h8000, "held select");
    wr(1'b1, 16'h0000);
    rd(1'b0, 16'h4000, "no stray write");
    do_reset();
    check1(stopped_r, 1'b1, "stopped after reset");
    check1(irq_n_r, 1'b1, "irq pin after reset");
    rd(1'b1, 16'h0000, "address port reset");
    rd(1'b0, 16'h4000, "primary reset");
    @(posedge sys_clk) start_prim <= 1'b1;
    @(posedge sys_clk) start_prim <= 1'b0;
    cyc(3);
    check1(tx_ring_active_r, 1'b1, "tx on after start");
    check1(rx_ring_active_r, 1'b1, "rx on after start");
    wr(1'b0, 16'h0200);
    rd(1'b0, 16'h0e00, "enable set");
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk) cause_set <= 7'(1 << k);
      @(posedge sys_clk) cause_set <= 7'h00;
      cyc(1);
      check1(irq_n_r, 1'b0, "irq pin asserted");
      rd(1'b0, 16'h0f00 | 16'(2 << k), "cause set");
      wr(1'b0, 16'h0200);
      rd(1'b0, 16'h0f00 | 16'(2 << k), "zero write kept cause");
      wr(1'b0, 16'h0000);
      check1(irq_n_r, 1'b1, "irq pin masked");
      wr(1'b0, 16'h0200 | 16'(2 << k));
      rd(1'b0, 16'h0e00, "cause cleared");
    end
    wr(1'b0, 16'h8200);
    check1(transmit_demand_r, 1'b1, "demand set");
    @(posedge sys_clk) demand_taken <= 1'b1;
    @(posedge sys_clk) demand_taken <= 1'b0;
    cyc(1);
    check1(transmit_demand_r, 1'b0, "demand consumed");
    tx_frame_busy <= 1'b1;
    wr(1'b0, 16'h2200);
    cyc(4);
    check1(tx_ring_active_r, 1'b1, "tx frame finishing");
    tx_frame_busy <= 1'b0;
    cyc(3);
    check1(tx_ring_active_r, 1'b0, "tx off");
    link_up <= 1'b1;
    wr(1'b0, 16'h3200);
    cyc(3);
    check1(rx_ring_active_r, 1'b0, "rx off");
    check16(16'(rnr_cnt), 16'h0001, "busy response count");
    wr(1'b0, 16'h0200);
    cyc(3);
    check16(16'(rr_cnt), 16'h0001, "ready response count");
    rd(1'b0, 16'h0e00, "rings back on");
    dma_ready <= 1'b0;
    @(posedge sys_clk) dma_addr_strobe <= 1'b1;
    @(posedge sys_clk) dma_addr_strobe <= 1'b0;
    cyc(240);
    check1(irq_n_r, 1'b1, "no early memory error");
    cyc(30);
    check1(irq_n_r, 1'b0, "memory error irq");
    check1(tx_ring_active_r, 1'b0, "memory error stops tx");
    rd(1'b0, 16'h0380, "memory error flag");
    @(posedge sys_clk) stop_prim <= 1'b1;
    @(posedge sys_clk) stop_prim <= 1'b0;
    cyc(2);
    check1(stopped_r, 1'b1, "stopped by primitive");
    check1(irq_n_r, 1'b1, "irq pin after stop");
    rd(1'b0, 16'h4000, "primary after stop");
    wr(1'b1, 16'h0082);
    wr(1'b0, 16'h005a);
    wr(1'b1, 16'h0083);
    wr(1'b0, 16'h00a5);
    check1(byte_wide_mode_r, 1'b1, "byte mode");
    rd(1'b1, 16'h0083, "byte address port");
    rd(1'b0, 16'h00a5, "high byte");
    wr(1'b1, 16'h0082);
    rd(1'b0, 16'h005a, "low byte");
    final_report();
  end
endmodule
